// ===== daqcc_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Converter model
// ----------------------------------------
module daqcc_adc_model (
	// Clock
	input  wire logic                      clk,
	// Converter handshake
	input  wire logic                      start,
	input  wire daqcc_pkg::daqcc_adc_req_t req,
	output logic                           done,
	output logic [15:0]                    result
);
	logic [2:0] cnt_q;
	initial begin
		done = 1'h0;
		result = 16'h0000;
		cnt_q = 3'h0;
	end
	// Result follows the request; idle bus toggles
	always @(posedge clk) begin
		done <= (cnt_q == 3'h1);
		result <= (cnt_q == 3'h1) ? req : ~result;
		cnt_q <= start ? 3'h4 : ((cnt_q != 3'h0) ? cnt_q - 3'h1 : 3'h0);
	end
endmodule : daqcc_adc_model
`default_nettype wire

// ===== daqcc_pkg.sv
`default_nettype none
package daqcc_pkg;
	// ----------------------------------------
	// Register indexes (byte address = 4 x index)
	// ----------------------------------------
	localparam logic [10:0] IDX_IN_PORT    = 11'h000;
	localparam logic [10:0] IDX_IN_DSEL    = 11'h002;
	localparam logic [10:0] IDX_IN_CTLA    = 11'h004;
	localparam logic [10:0] IDX_IN_CTLC    = 11'h006;
	localparam logic [10:0] IDX_IN_STAT    = 11'h007;
	localparam logic [10:0] IDX_SCAN_LEN   = 11'h008;
	localparam logic [10:0] IDX_BURST_RATE = 11'h009;
	localparam logic [10:0] IDX_Q_START    = 11'h00A;
	localparam logic [10:0] IDX_OUT_FIFO   = 11'h400;
	localparam logic [10:0] IDX_OUT_DSEL   = 11'h402;
	localparam logic [10:0] IDX_OUT_RCNT   = 11'h403;
	localparam logic [10:0] IDX_OUT_CTLA   = 11'h404;
	localparam logic [10:0] IDX_OUT_CTLC   = 11'h406;
	localparam logic [10:0] IDX_OUT_STAT   = 11'h407;
	localparam logic [10:0] IDX_PACER_LO   = 11'h408;
	localparam logic [10:0] IDX_PACER_HI   = 11'h409;
	// ----------------------------------------
	// Field values and positions
	// ----------------------------------------
	localparam logic [7:0] FIFO_RESET      = 8'h00;
	localparam logic [7:0] FIFO_ON         = 8'h01;
	localparam logic [7:0] FIFO_RECYCLE    = 8'h03;
	localparam logic [7:0] SEL_DATA        = 8'h00;
	localparam logic [7:0] SEL_QUEUE       = 8'h01;
	localparam logic [1:0] SEL_DAC0        = 2'h0;
	localparam logic [1:0] SEL_DAC1        = 2'h1;
	localparam logic [1:0] SEL_BOTH        = 2'h2;
	localparam logic [1:0] SRC_SOFT        = 2'h0;
	localparam logic [1:0] SRC_INT_PACER   = 2'h1;
	localparam int         BIT_CONVERSION_ENABLE        = 7;
	localparam int         BIT_BUSY        = 6;
	localparam int         BIT_MASK        = 5;
	localparam int         BIT_PSEN        = 3;
	localparam logic [7:0] RESET_BYTE      = 8'h00;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int         CLK_NS          = 25;
	localparam int         HOLD_DLY_NS     = 50;
	localparam int         HOLD_TAIL_NS    = 200;
	localparam int         BURST_UNIT_NS   = 1000;
	localparam int         PACER_BASE_NS   = 200;
	localparam int         PRESCALE        = 10;
	localparam int         DAC_UPD_NS      = 1000;
	localparam logic [3:0]  HOLD_DLY_CYC   = 4'((HOLD_DLY_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0]  HOLD_TAIL_CYC  = 4'((HOLD_TAIL_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [13:0] BURST_CYC      = 14'(BURST_UNIT_NS / CLK_NS);
	localparam logic [6:0]  BASE_CYC       = 7'(PACER_BASE_NS / CLK_NS);
	localparam logic [6:0]  BASE_PS_CYC    = 7'(PRESCALE * PACER_BASE_NS / CLK_NS);
	localparam logic [5:0]  DAC_UPD_CYC    = 6'(DAC_UPD_NS / CLK_NS);
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] gain;
		logic [7:0] chan;
	} daqcc_adc_req_t;
	typedef struct packed {
		logic [15:0] dac0;
		logic [15:0] dac1;
	} daqcc_dac_out_t;
	typedef enum {S_IDLE, S_WAIT, S_TAIL} daqcc_scan_t;
	typedef enum {D_IDLE, D_POP0, D_POP1, D_SETTLE} daqcc_dac_st_t;
endpackage : daqcc_pkg
`default_nettype wire

// ===== daqcc_top.sv
`timescale 1ns/10ps
`default_nettype none
module daqcc_top (
	// Clock and reset
	input  wire logic                     CLK,
	input  wire logic                     RESET,
	// APB slave
	input  wire logic                     PSEL,
	input  wire logic                     PENABLE,
	input  wire logic                     PWRITE,
	input  wire logic [31:0]              PADDR,
	input  wire logic [31:0]              PWDATA,
	output logic                          PREADY,
	output logic      [31:0]              PRDATA,
	output logic                          PSLVERR,
	// Input converter
	input  wire logic                     PACER_IN,
	input  wire logic                     ADC_DONE,
	input  wire logic [15:0]              ADC_RESULT,
	output logic                          ADC_START,
	output daqcc_pkg::daqcc_adc_req_t     ADC_REQ,
	output logic                          HOLD_CTRL,
	// Output converters
	output daqcc_pkg::daqcc_dac_out_t     DAC_OUT,
	output logic                          DAC_LOAD
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]  in_dsel_q, in_dsel_d, in_ctla_q, in_ctla_d, in_ctlc_q, in_ctlc_d;
	logic [7:0]  scan_len_q, scan_len_d, burst_rate_q, burst_rate_d, q_start_q, q_start_d;
	logic [7:0]  q_ptr_q, q_ptr_d, chan_left_q, chan_left_d;
	logic [7:0]  out_dsel_q, out_dsel_d, out_rcnt_q, out_rcnt_d, out_ctla_q, out_ctla_d;
	logic [7:0]  out_ctlc_q, out_ctlc_d, pacer_lo_q, pacer_lo_d, pacer_hi_q, pacer_hi_d;
	logic        in_conversion_enable_q, in_conversion_enable_d, out_conversion_enable_q, out_conversion_enable_d, out_busy_q, out_busy_d;
	logic        pready_q, pready_d, pslverr_q, pslverr_d, pacer_prev_q;
	logic [31:0] prdata_q, prdata_d;
	logic [4:0]  ad_wp_q, ad_wp_d, ad_rp_q, ad_rp_d;
	logic [12:0] da_wp_q, da_wp_d, da_rp_q, da_rp_d;
	logic [13:0] bcnt_q, bcnt_d;
	logic [3:0]  hdly_q, hdly_d, tcnt_q, tcnt_d;
	logic [6:0]  pre_q, pre_d;
	logic [15:0] pacer_cnt_q, pacer_cnt_d;
	logic [5:0]  ucnt_q, ucnt_d;
	logic        adc_start_q, adc_start_d, hold_q, hold_d, dac_load_q, dac_load_d;
	daqcc_pkg::daqcc_adc_req_t adc_req_q, adc_req_d;
	daqcc_pkg::daqcc_dac_out_t dac_q, dac_d;
	daqcc_pkg::daqcc_scan_t    st_q, st_d;
	daqcc_pkg::daqcc_dac_st_t  dst_q, dst_d;
	logic [15:0] ad_mem [0:15];
	logic [15:0] queue_mem [0:255];
	logic [15:0] da_mem [0:4095];
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic        acc, done, wr, mapped, ad_full, ad_has, da_avail, recycle;
	logic        ad_push, ad_pop, q_write, da_push, da_pop, pacer_rise, base_tick, trig;
	logic [10:0] idx;
	logic [13:0] burst_per;
	logic [12:0] rec_len, rp_inc;
	daqcc_pkg::daqcc_adc_req_t q_head;
	assign acc       = PSEL & PENABLE;
	assign done      = acc & pready_q;
	assign wr        = done & PWRITE;
	assign idx       = PADDR[12:2];
	assign ad_full   = (ad_wp_q[3:0] == ad_rp_q[3:0]) & (ad_wp_q[4] != ad_rp_q[4]);
	assign ad_has    = ad_wp_q != ad_rp_q;
	assign recycle   = out_ctla_q[1];
	assign rec_len   = (13'({out_dsel_q[7:5], out_rcnt_q}) + 13'h1) << (out_dsel_q[1:0] == daqcc_pkg::SEL_BOTH);
	assign da_avail  = recycle ? (da_wp_q != 13'h0) : (da_wp_q != da_rp_q);
	assign rp_inc    = da_rp_q + 13'h1;
	assign burst_per = 14'((burst_rate_q + 14'h1) * daqcc_pkg::BURST_CYC);
	assign q_head    = daqcc_pkg::daqcc_adc_req_t'(queue_mem[q_ptr_q]);
	assign pacer_rise = PACER_IN & ~pacer_prev_q;
	assign base_tick = pre_q == 7'h0;
	always_comb begin
		case (idx)
			daqcc_pkg::IDX_IN_PORT, daqcc_pkg::IDX_IN_DSEL, daqcc_pkg::IDX_IN_CTLA, daqcc_pkg::IDX_IN_CTLC,
			daqcc_pkg::IDX_IN_STAT, daqcc_pkg::IDX_SCAN_LEN, daqcc_pkg::IDX_BURST_RATE, daqcc_pkg::IDX_Q_START,
			daqcc_pkg::IDX_OUT_FIFO, daqcc_pkg::IDX_OUT_DSEL, daqcc_pkg::IDX_OUT_RCNT, daqcc_pkg::IDX_OUT_CTLA,
			daqcc_pkg::IDX_OUT_CTLC, daqcc_pkg::IDX_OUT_STAT, daqcc_pkg::IDX_PACER_LO,
			daqcc_pkg::IDX_PACER_HI: mapped = PADDR[31:13] == 19'h0;
			default: mapped = 1'b0;
		endcase
	end
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		in_dsel_d = in_dsel_q;       in_ctla_d = in_ctla_q;       in_ctlc_d = in_ctlc_q;
		scan_len_d = scan_len_q;     burst_rate_d = burst_rate_q; q_start_d = q_start_q;
		q_ptr_d = q_ptr_q;           chan_left_d = chan_left_q;   out_dsel_d = out_dsel_q;
		out_rcnt_d = out_rcnt_q;     out_ctla_d = out_ctla_q;     out_ctlc_d = out_ctlc_q;
		pacer_lo_d = pacer_lo_q;     pacer_hi_d = pacer_hi_q;     in_conversion_enable_d = in_conversion_enable_q;
		out_conversion_enable_d = out_conversion_enable_q;     out_busy_d = out_busy_q;     prdata_d = prdata_q;
		ad_wp_d = ad_wp_q;           ad_rp_d = ad_rp_q;           da_wp_d = da_wp_q;
		da_rp_d = da_rp_q;           bcnt_d = bcnt_q;             tcnt_d = tcnt_q;
		ucnt_d = ucnt_q;             adc_req_d = adc_req_q;       dac_d = dac_q;
		st_d = st_q;                 dst_d = dst_q;               hold_d = hold_q;
		hdly_d = (hdly_q != 4'h0) ? hdly_q - 4'h1 : 4'h0;
		adc_start_d = 1'b0;          dac_load_d = 1'b0;           da_pop = 1'b0;
		pready_d = acc & ~pready_q;
		pslverr_d = acc & ~pready_q & ~mapped;
		ad_push = ADC_DONE & (in_ctla_q == daqcc_pkg::FIFO_ON) & ~ad_full;
		ad_pop = done & ~PWRITE & mapped & (idx == daqcc_pkg::IDX_IN_PORT)
			& (in_dsel_q == daqcc_pkg::SEL_DATA) & ad_has;
		q_write = wr & mapped & (idx == daqcc_pkg::IDX_IN_PORT) & (in_dsel_q == daqcc_pkg::SEL_QUEUE);
		da_push = wr & mapped & (idx == daqcc_pkg::IDX_OUT_FIFO) & out_ctla_q[0];
		// Read mux, registered in the first access cycle
		if (acc & ~pready_q) begin
			prdata_d = 32'h0;
			if (mapped & ~PWRITE) begin
				case (idx)
					daqcc_pkg::IDX_IN_PORT:    prdata_d = (in_dsel_q == daqcc_pkg::SEL_QUEUE) ?
						{16'h0, queue_mem[q_ptr_q]} : {16'h0, ad_mem[ad_rp_q[3:0]]};
					daqcc_pkg::IDX_IN_DSEL:    prdata_d = {24'h0, in_dsel_q};
					daqcc_pkg::IDX_IN_CTLA:    prdata_d = {24'h0, in_ctla_q};
					daqcc_pkg::IDX_IN_CTLC:    prdata_d = {24'h0, in_ctlc_q};
					daqcc_pkg::IDX_IN_STAT:    prdata_d = {24'h0, in_conversion_enable_q, ad_has, 6'h0};
					daqcc_pkg::IDX_SCAN_LEN:   prdata_d = {24'h0, scan_len_q};
					daqcc_pkg::IDX_BURST_RATE: prdata_d = {24'h0, burst_rate_q};
					daqcc_pkg::IDX_Q_START:    prdata_d = {24'h0, q_start_q};
					daqcc_pkg::IDX_OUT_DSEL:   prdata_d = {24'h0, out_dsel_q};
					daqcc_pkg::IDX_OUT_RCNT:   prdata_d = {24'h0, out_rcnt_q};
					daqcc_pkg::IDX_OUT_CTLA:   prdata_d = {24'h0, out_ctla_q};
					daqcc_pkg::IDX_OUT_CTLC:   prdata_d = {24'h0, out_ctlc_q};
					daqcc_pkg::IDX_OUT_STAT:   prdata_d = {24'h0, out_conversion_enable_q, out_busy_q, 6'h0};
					daqcc_pkg::IDX_PACER_LO:   prdata_d = {24'h0, pacer_lo_q};
					daqcc_pkg::IDX_PACER_HI:   prdata_d = {24'h0, pacer_hi_q};
					default:                   prdata_d = 32'h0;
				endcase
			end
		end
		// Register writes
		if (wr & mapped) begin
			case (idx)
				daqcc_pkg::IDX_IN_DSEL:    in_dsel_d = PWDATA[7:0];
				daqcc_pkg::IDX_IN_CTLA:    in_ctla_d = PWDATA[7:0];
				daqcc_pkg::IDX_IN_CTLC:    in_ctlc_d = PWDATA[7:0];
				daqcc_pkg::IDX_IN_STAT:    in_conversion_enable_d = PWDATA[daqcc_pkg::BIT_CONVERSION_ENABLE];
				daqcc_pkg::IDX_SCAN_LEN:   scan_len_d = PWDATA[7:0];
				daqcc_pkg::IDX_BURST_RATE: burst_rate_d = PWDATA[7:0];
				daqcc_pkg::IDX_Q_START:    q_start_d = PWDATA[7:0];
				daqcc_pkg::IDX_OUT_DSEL:   out_dsel_d = PWDATA[7:0];
				daqcc_pkg::IDX_OUT_RCNT:   out_rcnt_d = PWDATA[7:0];
				daqcc_pkg::IDX_OUT_CTLA:   out_ctla_d = PWDATA[7:0];
				daqcc_pkg::IDX_OUT_CTLC:   out_ctlc_d = PWDATA[7:0];
				daqcc_pkg::IDX_OUT_STAT: begin
					if (!PWDATA[daqcc_pkg::BIT_MASK])
						out_conversion_enable_d = PWDATA[daqcc_pkg::BIT_CONVERSION_ENABLE];
				end
				daqcc_pkg::IDX_PACER_LO:   pacer_lo_d = PWDATA[7:0];
				daqcc_pkg::IDX_PACER_HI:   pacer_hi_d = PWDATA[7:0];
				default: ;
			endcase
		end
		// Input FIFO and queue pointer
		if (ad_push)
			ad_wp_d = ad_wp_q + 5'h1;
		if (ad_pop)
			ad_rp_d = ad_rp_q + 5'h1;
		if (in_ctla_q == daqcc_pkg::FIFO_RESET) begin
			ad_wp_d = 5'h0;
			ad_rp_d = 5'h0;
		end
		if (q_write)
			q_ptr_d = (q_ptr_q == 8'h0) ? q_start_q : q_ptr_q - 8'h1;
		// Scan sequencer and hold output
		case (st_q)
			daqcc_pkg::S_IDLE: begin
				if (in_conversion_enable_q & (in_ctlc_q[1:0] != daqcc_pkg::SRC_SOFT) & pacer_rise) begin
					st_d = daqcc_pkg::S_WAIT;
					hdly_d = daqcc_pkg::HOLD_DLY_CYC;
					bcnt_d = burst_per - 14'h1;
					chan_left_d = scan_len_q;
				end else if (wr & mapped & (idx == daqcc_pkg::IDX_IN_PORT)
					& (in_dsel_q == daqcc_pkg::SEL_DATA) & in_conversion_enable_q
					& (in_ctlc_q[1:0] == daqcc_pkg::SRC_SOFT)) begin
					adc_start_d = 1'b1;
					adc_req_d = q_head;
					q_ptr_d = (q_ptr_q == 8'h0) ? q_start_q : q_ptr_q - 8'h1;
				end
			end
			daqcc_pkg::S_WAIT: begin
				if (bcnt_q == 14'h0) begin
					adc_start_d = 1'b1;
					adc_req_d = q_head;
					q_ptr_d = (q_ptr_q == 8'h0) ? q_start_q : q_ptr_q - 8'h1;
					bcnt_d = burst_per - 14'h1;
					chan_left_d = chan_left_q - 8'h1;
					if (chan_left_q == 8'h0) begin
						st_d = daqcc_pkg::S_TAIL;
						tcnt_d = daqcc_pkg::HOLD_TAIL_CYC;
					end
				end else
					bcnt_d = bcnt_q - 14'h1;
			end
			daqcc_pkg::S_TAIL: begin
				tcnt_d = tcnt_q - 4'h1;
				if (tcnt_q == 4'h1) begin
					hold_d = 1'b0;
					st_d = daqcc_pkg::S_IDLE;
				end
			end
			default: st_d = daqcc_pkg::S_IDLE;
		endcase
		if (hdly_q == 4'h1)
			hold_d = 1'b1;
		if (!in_conversion_enable_q) begin
			st_d = daqcc_pkg::S_IDLE;
			hold_d = 1'b0;
		end
		if (wr & mapped & (idx == daqcc_pkg::IDX_Q_START))
			q_ptr_d = PWDATA[7:0];
		// Output pacer counter
		pre_d = base_tick ? (out_ctlc_q[daqcc_pkg::BIT_PSEN] ? daqcc_pkg::BASE_PS_CYC
			: daqcc_pkg::BASE_CYC) - 7'h1 : pre_q - 7'h1;
		pacer_cnt_d = pacer_cnt_q;
		if (base_tick)
			pacer_cnt_d = (pacer_cnt_q == 16'h0) ? {pacer_hi_q, pacer_lo_q} : pacer_cnt_q - 16'h1;
		trig = (base_tick & (pacer_cnt_q == 16'h0) & (out_ctlc_q[1:0] == daqcc_pkg::SRC_INT_PACER))
			| (wr & mapped & (idx == daqcc_pkg::IDX_OUT_STAT) & PWDATA[daqcc_pkg::BIT_BUSY]);
		// Output update sequencer
		case (dst_q)
			daqcc_pkg::D_IDLE: begin
				if (trig & out_conversion_enable_q) begin
					out_busy_d = 1'b1;
					dst_d = daqcc_pkg::D_POP0;
				end
			end
			daqcc_pkg::D_POP0: begin
				if (da_avail) begin
					da_pop = 1'b1;
					if (out_dsel_q[1:0] == daqcc_pkg::SEL_DAC1)
						dac_d.dac1 = da_mem[da_rp_q[11:0]];
					else
						dac_d.dac0 = da_mem[da_rp_q[11:0]];
				end
				dst_d = (out_dsel_q[1:0] == daqcc_pkg::SEL_BOTH) ? daqcc_pkg::D_POP1 : daqcc_pkg::D_SETTLE;
				if (out_dsel_q[1:0] != daqcc_pkg::SEL_BOTH) begin
					dac_load_d = 1'b1;
					ucnt_d = daqcc_pkg::DAC_UPD_CYC;
				end
			end
			daqcc_pkg::D_POP1: begin
				if (da_avail) begin
					da_pop = 1'b1;
					dac_d.dac1 = da_mem[da_rp_q[11:0]];
				end
				dac_load_d = 1'b1;
				ucnt_d = daqcc_pkg::DAC_UPD_CYC;
				dst_d = daqcc_pkg::D_SETTLE;
			end
			daqcc_pkg::D_SETTLE: begin
				ucnt_d = ucnt_q - 6'h1;
				if (ucnt_q == 6'h1) begin
					out_busy_d = 1'b0;
					dst_d = daqcc_pkg::D_IDLE;
				end
			end
			default: dst_d = daqcc_pkg::D_IDLE;
		endcase
		if (da_push)
			da_wp_d = da_wp_q + 13'h1;
		if (da_pop)
			da_rp_d = (recycle & (rp_inc == rec_len)) ? 13'h0 : rp_inc;
		if (out_ctla_q == daqcc_pkg::FIFO_RESET) begin
			da_wp_d = 13'h0;
			da_rp_d = 13'h0;
		end
	end
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			in_dsel_q <= daqcc_pkg::RESET_BYTE;   in_ctla_q <= daqcc_pkg::RESET_BYTE;
			in_ctlc_q <= daqcc_pkg::RESET_BYTE;   scan_len_q <= daqcc_pkg::RESET_BYTE;
			burst_rate_q <= daqcc_pkg::RESET_BYTE; q_start_q <= daqcc_pkg::RESET_BYTE;
			q_ptr_q <= daqcc_pkg::RESET_BYTE;     chan_left_q <= daqcc_pkg::RESET_BYTE;
			out_dsel_q <= daqcc_pkg::RESET_BYTE;  out_rcnt_q <= daqcc_pkg::RESET_BYTE;
			out_ctla_q <= daqcc_pkg::RESET_BYTE;  out_ctlc_q <= daqcc_pkg::RESET_BYTE;
			pacer_lo_q <= daqcc_pkg::RESET_BYTE;  pacer_hi_q <= daqcc_pkg::RESET_BYTE;
			in_conversion_enable_q <= 1'b0;    out_conversion_enable_q <= 1'b0;   out_busy_q <= 1'b0;
			pready_q <= 1'b0;     pslverr_q <= 1'b0;    prdata_q <= 32'h0;
			pacer_prev_q <= 1'b0; ad_wp_q <= 5'h0;      ad_rp_q <= 5'h0;
			da_wp_q <= 13'h0;     da_rp_q <= 13'h0;     bcnt_q <= 14'h0;
			hdly_q <= 4'h0;       tcnt_q <= 4'h0;       pre_q <= 7'h0;
			pacer_cnt_q <= 16'h0; ucnt_q <= 6'h0;       adc_start_q <= 1'b0;
			hold_q <= 1'b0;       dac_load_q <= 1'b0;   adc_req_q <= '0;
			dac_q <= '0;          st_q <= daqcc_pkg::S_IDLE; dst_q <= daqcc_pkg::D_IDLE;
		end else begin
			in_dsel_q <= in_dsel_d;       in_ctla_q <= in_ctla_d;       in_ctlc_q <= in_ctlc_d;
			scan_len_q <= scan_len_d;     burst_rate_q <= burst_rate_d; q_start_q <= q_start_d;
			q_ptr_q <= q_ptr_d;           chan_left_q <= chan_left_d;   out_dsel_q <= out_dsel_d;
			out_rcnt_q <= out_rcnt_d;     out_ctla_q <= out_ctla_d;     out_ctlc_q <= out_ctlc_d;
			pacer_lo_q <= pacer_lo_d;     pacer_hi_q <= pacer_hi_d;     in_conversion_enable_q <= in_conversion_enable_d;
			out_conversion_enable_q <= out_conversion_enable_d;     out_busy_q <= out_busy_d;     pready_q <= pready_d;
			pslverr_q <= pslverr_d;       prdata_q <= prdata_d;         pacer_prev_q <= PACER_IN;
			ad_wp_q <= ad_wp_d;           ad_rp_q <= ad_rp_d;           da_wp_q <= da_wp_d;
			da_rp_q <= da_rp_d;           bcnt_q <= bcnt_d;             hdly_q <= hdly_d;
			tcnt_q <= tcnt_d;             pre_q <= pre_d;               pacer_cnt_q <= pacer_cnt_d;
			ucnt_q <= ucnt_d;             adc_start_q <= adc_start_d;   hold_q <= hold_d;
			dac_load_q <= dac_load_d;     adc_req_q <= adc_req_d;       dac_q <= dac_d;
			st_q <= st_d;                 dst_q <= dst_d;
		end
	end
	// ----------------------------------------
	// Memories
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (ad_push)
			ad_mem[ad_wp_q[3:0]] <= ADC_RESULT;
		if (q_write)
			queue_mem[q_ptr_q] <= PWDATA[15:0];
		if (da_push)
			da_mem[da_wp_q[11:0]] <= PWDATA[15:0];
	end
	assign PREADY    = pready_q;
	assign PRDATA    = prdata_q;
	assign PSLVERR   = pslverr_q;
	assign ADC_START = adc_start_q;
	assign ADC_REQ   = adc_req_q;
	assign HOLD_CTRL = hold_q;
	assign DAC_OUT   = dac_q;
	assign DAC_LOAD  = dac_load_q;
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	property p_in_fifo_reset;
		wr & mapped & (idx == daqcc_pkg::IDX_IN_CTLA) & (PWDATA[7:0] == 8'h00) |=> ##1 (ad_wp_q == 5'h0);
	endproperty
	a_in_fifo_reset: assert property (p_in_fifo_reset) else $error("input FIFO not cleared");
	property p_in_conversion_enable;
		wr & mapped & (idx == daqcc_pkg::IDX_IN_STAT) |=> in_conversion_enable_q == $past(PWDATA[7]);
	endproperty
	a_in_conversion_enable: assert property (p_in_conversion_enable) else $error("input enable not written");
	property p_qptr;
		wr & mapped & (idx == daqcc_pkg::IDX_Q_START) |=> q_ptr_q == $past(PWDATA[7:0]);
	endproperty
	a_qptr: assert property (p_qptr) else $error("queue pointer not reloaded");
	property p_hold_rise;
		(st_q == daqcc_pkg::S_IDLE) & (st_d == daqcc_pkg::S_WAIT) |-> ##3 HOLD_CTRL;
	endproperty
	a_hold_rise: assert property (p_hold_rise) else $error("hold not raised after pacer");
	property p_hold_fall;
		ADC_START & (st_q == daqcc_pkg::S_TAIL) |-> HOLD_CTRL[*8] ##1 !HOLD_CTRL;
	endproperty
	a_hold_fall: assert property (p_hold_fall) else $error("hold tail wrong");
	property p_conversion_enable_mask;
		wr & mapped & (idx == daqcc_pkg::IDX_OUT_STAT) & PWDATA[5] |=> $stable(out_conversion_enable_q);
	endproperty
	a_conversion_enable_mask: assert property (p_conversion_enable_mask) else $error("masked enable changed");
	property p_output_converting_end;
		(dst_q == daqcc_pkg::D_SETTLE) & (ucnt_q == 6'h1) |=> !out_busy_q && (dst_q == daqcc_pkg::D_IDLE);
	endproperty
	a_output_converting_end: assert property (p_output_converting_end) else $error("converting flag stuck");
	property p_pacer_reload;
		base_tick & (pacer_cnt_q == 16'h0) |=> pacer_cnt_q == {$past(pacer_hi_q), $past(pacer_lo_q)};
	endproperty
	a_pacer_reload: assert property (p_pacer_reload) else $error("pacer not reloaded");
	property p_recycle;
		da_pop & recycle & (rp_inc == rec_len) & (out_ctla_q != 8'h00) |=> da_rp_q == 13'h0;
	endproperty
	a_recycle: assert property (p_recycle) else $error("recycle wrap missed");
endmodule : daqcc_top
`default_nettype wire

// ===== test_daqcc_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_daqcc_top;
	logic                      clk, rst, psel, pen, pwr, pready, err, slverr, pacer, done, start, hold, load;
	logic [31:0]               paddr, pwdata, prdata, rd;
	logic [15:0]               res;
	daqcc_pkg::daqcc_adc_req_t req;
	daqcc_pkg::daqcc_dac_out_t dac;
	int                        miscompares, checks, n, hs, s1, sl, hf;
	daqcc_top i_daqcc_top (.CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(slverr), .PACER_IN(pacer),
		.ADC_DONE(done), .ADC_RESULT(res), .ADC_START(start), .ADC_REQ(req), .HOLD_CTRL(hold),
		.DAC_OUT(dac), .DAC_LOAD(load));
	daqcc_adc_model i_daqcc_adc_model (.clk(clk), .start(start), .req(req), .done(done), .result(res));
	always #12.5 clk = ~clk;
	// ----------------------------------------
	// Bus cycles and checks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [10:0] idx, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= {19'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = slverr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask : apb
	task automatic close_out;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic sw_input;
		apb(1, daqcc_pkg::IDX_IN_CTLA, 8'h00);
		apb(1, daqcc_pkg::IDX_IN_CTLC, 8'hD0);
		apb(1, daqcc_pkg::IDX_IN_DSEL, 8'h01);
		apb(1, daqcc_pkg::IDX_Q_START, 8'h03);
		apb(1, daqcc_pkg::IDX_IN_PORT, 16'h0100);
		apb(1, daqcc_pkg::IDX_IN_PORT, 16'h0101);
		apb(1, daqcc_pkg::IDX_IN_PORT, 16'h0202);
		apb(1, daqcc_pkg::IDX_Q_START, 8'h03);
		apb(0, daqcc_pkg::IDX_IN_PORT, 0);
		chk(rd, 32'h0100);
		apb(1, daqcc_pkg::IDX_IN_DSEL, 8'h00);
		apb(1, daqcc_pkg::IDX_IN_CTLA, 8'h01);
		apb(1, daqcc_pkg::IDX_IN_STAT, 8'h80);
		apb(0, daqcc_pkg::IDX_IN_STAT, 0);
		chk(rd, 32'h80);
		apb(1, daqcc_pkg::IDX_IN_PORT, 16'hFFFF);
		for (n = 0; n < 10 && rd[6] !== 1'h1; n++) apb(0, daqcc_pkg::IDX_IN_STAT, 0);
		chk(rd, 32'hC0);
		apb(0, daqcc_pkg::IDX_IN_PORT, 0);
		chk(rd, 32'h0100);
		apb(1, daqcc_pkg::IDX_IN_STAT, 8'h00);
		apb(0, daqcc_pkg::IDX_IN_STAT, 0);
		chk(rd, 32'h00);
		apb(1, 11'h0FF, 0);
		chk(err, 1'h1);
	endtask : sw_input
	task automatic sw_output;
		apb(1, daqcc_pkg::IDX_OUT_CTLA, 8'h00);
		apb(1, daqcc_pkg::IDX_OUT_CTLC, 8'h80);
		apb(1, daqcc_pkg::IDX_OUT_DSEL, 8'h02);
		apb(1, daqcc_pkg::IDX_PACER_LO, 8'h01);
		apb(1, daqcc_pkg::IDX_PACER_HI, 8'h00);
		apb(1, daqcc_pkg::IDX_OUT_CTLA, 8'h01);
		apb(1, daqcc_pkg::IDX_OUT_STAT, 8'h80);
		apb(1, daqcc_pkg::IDX_OUT_FIFO, 16'h1234);
		apb(1, daqcc_pkg::IDX_OUT_FIFO, 16'h5678);
		apb(1, daqcc_pkg::IDX_OUT_STAT, 8'h60);
		for (n = 0; n < 10 && load !== 1'h1; n++) @(negedge clk);
		chk(load, 1'h1);
		chk(dac, 32'h12345678);
		apb(0, daqcc_pkg::IDX_OUT_STAT, 0);
		chk(rd, 32'hC0);
		for (n = 0; n < 30 && rd[6] !== 1'h0; n++) apb(0, daqcc_pkg::IDX_OUT_STAT, 0);
		chk(rd, 32'h80);
	endtask : sw_output
	task automatic replay_wave;
		apb(1, daqcc_pkg::IDX_OUT_STAT, 8'h00);
		apb(1, daqcc_pkg::IDX_OUT_CTLA, 8'h00);
		apb(1, daqcc_pkg::IDX_OUT_CTLC, 8'hC9);
		apb(1, daqcc_pkg::IDX_OUT_DSEL, 8'h02);
		apb(1, daqcc_pkg::IDX_OUT_RCNT, 8'h01);
		apb(1, daqcc_pkg::IDX_PACER_LO, 8'h01);
		apb(1, daqcc_pkg::IDX_PACER_HI, 8'h00);
		apb(1, daqcc_pkg::IDX_OUT_CTLA, 8'h03);
		apb(1, daqcc_pkg::IDX_OUT_FIFO, 16'h0A00);
		apb(1, daqcc_pkg::IDX_OUT_FIFO, 16'h0B00);
		apb(1, daqcc_pkg::IDX_OUT_FIFO, 16'h0C00);
		apb(1, daqcc_pkg::IDX_OUT_FIFO, 16'h0D00);
		apb(1, daqcc_pkg::IDX_OUT_STAT, 8'h80);
		hf = 0;
		for (n = 0; n < 1000 && hf < 3; n++) begin
			@(negedge clk);
			if (load === 1'h1) begin
				hf++;
				chk(dac, (hf == 2) ? 32'h0C000D00 : 32'h0A000B00);
			end
		end
		chk(32'(hf), 32'h3);
		apb(1, daqcc_pkg::IDX_OUT_STAT, 8'h00);
		apb(0, daqcc_pkg::IDX_OUT_STAT, 0);
		chk(rd, 32'h40);
	endtask : replay_wave
	task automatic paced_scan;
		apb(1, daqcc_pkg::IDX_IN_CTLA, 8'h01);
		apb(1, daqcc_pkg::IDX_IN_CTLC, 8'h01);
		apb(1, daqcc_pkg::IDX_SCAN_LEN, 8'h01);
		apb(1, daqcc_pkg::IDX_BURST_RATE, 8'h00);
		apb(1, daqcc_pkg::IDX_IN_STAT, 8'h80);
		@(posedge clk);
		pacer <= 1'h1;
		hs = 0;
		s1 = 0;
		hf = 0;
		for (n = 1; n < 150; n++) begin
			@(negedge clk);
			if (hold === 1'h1 && hs == 0) hs = n;
			if (start === 1'h1 && s1 == 0) s1 = n;
			if (start === 1'h1) sl = n;
			if (hold === 1'h0 && hs != 0 && hf == 0) hf = n;
		end
		chk(32'(hs), 32'h4);
		chk(32'(s1), 32'h2A);
		chk(32'(sl), 32'h52);
		chk(32'(hf), 32'h5A);
	endtask : paced_scan
	initial begin
		{clk, psel, pen, pwr, paddr, pwdata, pacer, miscompares, checks} = '0;
		rst = 1'h1;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		apb(0, daqcc_pkg::IDX_OUT_STAT, 0);
		chk(rd, 32'h00);
		sw_input;
		sw_output;
		paced_scan;
		replay_wave;
		close_out;
	end
	initial begin
		#500000;
		miscompares++;
		close_out;
	end
endmodule : test_daqcc_top
`default_nettype wire
